// File: rtl/mrw_handler.sv
// holding-register write handler: parses rtu frames, queues writes, echoes replies
// assumes an external uart delivering bytes, an end-of-frame pulse and line errors
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module mrw_handler (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] ownAddr,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxEnd,
  input wire logic rxErr,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txByte,
  input wire logic txReady,
  output logic wrValid,
  output logic [mrw_pkg::KIND_W-1:0] wrKind,
  output logic [15:0] wrAddr,
  output logic [15:0] wrData,
  input wire logic wrReady,
  output logic frameDrop
);
  import mrw_pkg::*;

  mrw_state_type state;
  mrw_state_type next_state;
  logic [7:0] bytes [8];
  logic [8:0] idx;
  logic [7:0] hiByte;
  logic [6:0] wordIdx;
  logic anyOk;
  logic pushed;
  logic frameBad;
  logic replyPend;
  logic pushValid;
  mrw_entry_type pushData;
  mrw_entry_type fifoData;
  logic [3:0] sendCnt;
  logic [2:0] txPos;
  logic [15:0] rxCrc;
  logic [15:0] txCrc;

  mrw_push_if #(.WIDTH(ENTRY_W)) pushBus ();

  function automatic logic writable(input logic [15:0] a);
    return !(((a >= MON_FIRST) && (a <= MON_LAST)) || ((a >= FLT_FIRST) && (a <= FLT_LAST)));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // header decode, valid once the matching bytes are in
  wire logic take = rxValid && rxReady;
  wire logic endTake = rxEnd && rxReady;
  wire logic [7:0] fnCode = bytes[1];
  wire logic isMine = (bytes[0] == ownAddr);
  wire logic isBcast = (bytes[0] == BCAST_ADDR);
  wire logic [15:0] fieldA = {bytes[2], bytes[3]};
  wire logic [15:0] fieldB = {bytes[4], bytes[5]};
  wire logic [7:0] byteCnt = bytes[6];
  wire logic cntOk = (fieldB != 16'h0000) && (fieldB <= MAX_REGS);
  wire logic bcOk = (byteCnt >= BC_MIN) && (byteCnt <= BC_MAX)
    && ({8'h00, byteCnt} == {fieldB[14:0], 1'b0});
  wire logic hdrMulti = (fnCode == FN_MULTI) && cntOk && bcOk && (isMine || isBcast);

  ////////////////////////////////////////////////////////////////////////////////
  // word assembly; a word is queued as its low byte arrives
  // single write data completes at byte five
  wire logic lowSingle = take && (idx == POS_SINGLE_LO) && (fnCode == FN_SINGLE)
    && (isMine || isBcast);
  wire logic lowMulti = take && (idx >= POS_FIRST_LO) && !idx[0] && hdrMulti
    && (16'(wordIdx) < fieldB);
  // high byte latched, then low byte
  wire logic [15:0] wordAddr = lowSingle ? fieldA : fieldA + 16'(wordIdx);
  wire logic [15:0] wordData = {lowSingle ? bytes[4] : hiByte, rxByte};
  // read-only areas never reach the queue
  wire logic wordGo = (lowSingle || lowMulti) && writable(wordAddr);

  ////////////////////////////////////////////////////////////////////////////////
  // end-of-frame verdict
  // any diagnosis data value passes
  // diagnosis only when addressed to us
  wire logic fnOk = ((fnCode == FN_SINGLE) && (idx == FRAME_SHORT) && anyOk)
    || ((fnCode == FN_DIAG) && (idx == FRAME_SHORT) && (fieldA == SUB_ECHO) && isMine)
    || (hdrMulti && (idx == FRAME_MULTI_HDR + 9'(byteCnt)) && anyOk);
  // line errors and crc mismatch kill the frame
  wire logic frameGood = !(frameBad || rxErr) && (rxCrc == CRC_GOOD) && fnOk
    && (isMine || isBcast);
  wire logic replyGo = frameGood && !isBcast;

  wire logic pushDone = pushValid && pushBus.ready;
  wire logic closeGo = endTake && pushed;
  wire logic next_pushValid = wordGo || closeGo || (pushValid && !pushBus.ready);
  wire logic canLoad = !txValid || txReady;
  wire logic loadByte = (state == ST_SEND) && canLoad && (sendCnt != RESP_LEN);
  // header bytes, then crc made here
  wire logic [7:0] txNext = (sendCnt < ECHO_HDR) ? bytes[sendCnt[2:0]]
    : (sendCnt == ECHO_HDR) ? txCrc[7:0] : txCrc[15:8];

  assign pushBus.valid = pushValid;
  assign pushBus.data = pushData;
  assign wrKind = fifoData.kind;
  assign wrAddr = fifoData.addr;
  assign wrData = fifoData.data;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencing: receive, close the write group, send the reply
  always_comb begin
    next_state = state;
    case (state)
      ST_RECV: begin
        if (endTake) begin
          next_state = pushed ? ST_CLOSE : (replyGo ? ST_SEND : ST_RECV);
        end
      end
      ST_CLOSE: begin
        if (pushDone) begin
          next_state = replyPend ? ST_SEND : ST_RECV;
        end
      end
      ST_SEND: begin
        if (canLoad && (sendCnt == RESP_LEN)) begin
          next_state = ST_RECV;
        end
      end
      default: next_state = ST_RECV;
    endcase
  end

  // rxReady low while sending or a word waits, so nothing is ever lost
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RECV;
      rxReady <= 1'b0;
      frameDrop <= 1'b0;
    end else begin
      state <= next_state;
      rxReady <= (next_state == ST_RECV) && !next_pushValid;
      frameDrop <= endTake && !frameGood;
    end
  end

  // first eight bytes kept for decode and echo
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) begin
        bytes[i] <= 8'h00;
      end
    end else if (take && !endTake && (idx < FRAME_SHORT)) begin
      bytes[idx[2:0]] <= rxByte;
    end
  end

  // frame position, word tracking, error stickiness (end-of-frame clear beats error set)
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx <= '0;
      hiByte <= 8'h00;
      wordIdx <= '0;
      anyOk <= 1'b0;
      pushed <= 1'b0;
      frameBad <= 1'b0;
      replyPend <= 1'b0;
    end else if (endTake) begin
      idx <= '0;
      wordIdx <= '0;
      anyOk <= 1'b0;
      pushed <= 1'b0;
      frameBad <= 1'b0;
      replyPend <= replyGo;
    end else begin
      frameBad <= frameBad || rxErr;
      if (take) begin
        idx <= (idx == IDX_MAX) ? idx : idx + 9'h001;
        hiByte <= ((idx >= POS_DATA_HI) && idx[0]) ? rxByte : hiByte;
        wordIdx <= lowMulti ? wordIdx + 7'h01 : wordIdx;
        anyOk <= anyOk || wordGo;
        pushed <= pushed || wordGo;
      end
    end
  end

  // writes queued even for broadcast, closed by commit or abort
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pushValid <= 1'b0;
      pushData <= '0;
    end else begin
      pushValid <= next_pushValid;
      if (wordGo) begin
        pushData <= '{kind: KIND_DATA, addr: wordAddr, data: wordData};
      end else if (closeGo) begin
        pushData <= '{kind: frameGood ? KIND_COMMIT : KIND_ABORT, addr: fieldA, data: 16'h0000};
      end
    end
  end

  // reply bytes one at a time under txReady
  // diagnosis echo equals query since the crc is recomputed over the same bytes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txValid <= 1'b0;
      txByte <= 8'h00;
      sendCnt <= '0;
      txPos <= '0;
    end else if (state != ST_SEND) begin
      sendCnt <= '0;
    end else if (loadByte) begin
      txValid <= 1'b1;
      txByte <= txNext;
      txPos <= sendCnt[2:0];
      sendCnt <= sendCnt + 4'h1;
    end else if (canLoad) begin
      txValid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // crc check of the incoming frame, crc build of the reply
  mrw_crc rxCheck (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clr((state != ST_RECV) || endTake),
    .en(take),
    .din(rxByte),
    .crc(rxCrc)
  );

  mrw_crc txGen (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clr(state != ST_SEND),
    .en(loadByte && (sendCnt < ECHO_HDR)),
    .din(txNext),
    .crc(txCrc)
  );

  // queue decouples slow register writes from the serial line
  mrw_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) wrQueue (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .inPort(pushBus),
    .outValid(wrValid),
    .outData(fifoData),
    .outReady(wrReady)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_bcast_silent: assert property (txValid |-> !isBcast)
    else $error("reply sent for a broadcast frame");
  a_echo_bytes: assert property (txValid && (txPos < 3'(ECHO_HDR)) |-> txByte == bytes[txPos])
    else $error("reply header differs from query");
  a_crc_low: assert property (txValid && (txPos == 3'(ECHO_HDR)) |-> txByte == txCrc[7:0])
    else $error("crc low byte not in position six");
  a_crc_high: assert property (txValid && (txPos == 3'h7) |-> txByte == txCrc[15:8])
    else $error("crc high byte not last");
  a_diag_unicast: assert property (txValid && (fnCode == FN_DIAG)
    |-> isMine && (fieldA == SUB_ECHO))
    else $error("diagnosis answered when it should be ignored");
  a_multi_count: assert property (txValid && (fnCode == FN_MULTI) |-> cntOk && bcOk)
    else $error("multiple write answered with bad count");
  a_write_area: assert property (pushValid && (pushData.kind == KIND_DATA)
    |-> writable(pushData.addr))
    else $error("write queued to a read-only area");
  a_push_hold: assert property (pushValid && !pushBus.ready
    |=> pushValid && $stable(pushData))
    else $error("queued word changed while stalled");
  a_err_silent: assert property (endTake && (frameBad || rxErr)
    |=> frameDrop && (state != ST_SEND))
    else $error("errored frame was not dropped");
  a_rx_stall: assert property (pushValid |-> !rxReady)
    else $error("bytes taken while a word waits");
  a_reply_end: assert property (txValid && txReady && (txPos == 3'h7)
    |=> !txValid && (state == ST_RECV))
    else $error("reply longer than eight bytes");

  c_single_echo: cover property (txValid && txReady && (txPos == 3'h7) && (fnCode == FN_SINGLE));
  c_diag_echo: cover property (txValid && txReady && (txPos == 3'h7) && (fnCode == FN_DIAG));
  c_multi_reply: cover property (txValid && txReady && (txPos == 3'h7) && (fnCode == FN_MULTI));
  c_bcast_commit: cover property (pushDone && (pushData.kind == KIND_COMMIT) && isBcast);
endmodule

`default_nettype wire

// File: rtl/mrw_pkg.sv
// constants, entry layout and state codes for the register write handler
// assumes byte framing and the end-of-frame gap come from a uart outside
package mrw_pkg;
  // function and address codes on the wire
  localparam logic [7:0] FN_SINGLE = 8'h06;
  localparam logic [7:0] FN_DIAG = 8'h08;
  localparam logic [7:0] FN_MULTI = 8'h10;
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [15:0] SUB_ECHO = 16'h0000;
  localparam logic [15:0] MAX_REGS = 16'h007D;
  localparam logic [7:0] BC_MIN = 8'h02;
  localparam logic [7:0] BC_MAX = 8'hFA;
  // crc-16 seed, reflected polynomial and residue of a clean frame
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  // read-only holding areas (monitor and fault history), field values
  localparam logic [15:0] MON_FIRST = 16'h00C8;
  localparam logic [15:0] MON_LAST = 16'h01F3;
  localparam logic [15:0] FLT_FIRST = 16'h01F4;
  localparam logic [15:0] FLT_LAST = 16'h01FF;
  // byte positions and lengths within a frame
  localparam logic [8:0] POS_SINGLE_LO = 9'h005;
  localparam logic [8:0] POS_DATA_HI = 9'h007;
  localparam logic [8:0] POS_FIRST_LO = 9'h008;
  localparam logic [8:0] FRAME_SHORT = 9'h008;
  localparam logic [8:0] FRAME_MULTI_HDR = 9'h009;
  localparam logic [8:0] IDX_MAX = 9'h1FF;
  localparam logic [3:0] ECHO_HDR = 4'h6;
  localparam logic [3:0] RESP_LEN = 4'h8;
  // write stream entry kinds
  localparam int KIND_W = 2;
  localparam logic [KIND_W-1:0] KIND_DATA = 2'h0;
  localparam logic [KIND_W-1:0] KIND_COMMIT = 2'h1;
  localparam logic [KIND_W-1:0] KIND_ABORT = 2'h2;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [KIND_W-1:0] kind;
    logic [15:0] addr;
    logic [15:0] data;
  } mrw_entry_type;

  localparam int ENTRY_W = $bits(mrw_entry_type);

  typedef enum logic [1:0] {
    ST_RECV = 2'b00,
    ST_CLOSE = 2'b01,
    ST_SEND = 2'b10
  } mrw_state_type;
endpackage

// File: rtl/mrw_push_if.sv
// valid/ready carrier between the frame parser and the write queue
// assumes both ends share core_clk
`timescale 1ns/1ns
`default_nettype none

interface mrw_push_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

`default_nettype wire

// File: rtl/mrw_crc.sv
// byte-wide crc-16 accumulator, reflected, seeded on clear
// assumes clr and en are never needed in the same cycle (clr wins)
`timescale 1ns/1ns
`default_nettype none

module mrw_crc (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [15:0] crc
);
  import mrw_pkg::*;

  // eight shift steps per byte, lsb first
  function automatic logic [15:0] step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      crc <= CRC_INIT;
    end else if (clr) begin
      crc <= CRC_INIT;
    end else if (en) begin
      crc <= step(crc, din);
    end
  end
endmodule

`default_nettype wire

// File: rtl/mrw_fifo.sv
// queue with a registered output stage; DEPTH must be a power of two
// assumes the consumer holds outReady as it likes; fills honestly
`timescale 1ns/1ns
`default_nettype none

module mrw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  mrw_push_if.snk inPort,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;

  // full stalls the parser, which stalls the uart
  wire logic doPush = inPort.valid && inPort.ready;
  wire logic doPop = (count != '0) && (!outValid || outReady);
  assign inPort.ready = (count != (AW+1)'(DEPTH));

  // storage needs no reset, it is only read behind count
  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr] <= inPort.data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= doPush ? wrPtr + AW'(1) : wrPtr;
      rdPtr <= doPop ? rdPtr + AW'(1) : rdPtr;
      count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

  // output stage keeps the head in a flop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      outValid <= 1'b0;
      outData <= '0;
    end else if (doPop) begin
      outValid <= 1'b1;
      outData <= mem[rdPtr];
    end else if (outReady) begin
      outValid <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// File: verification/mrw_master_model.sv
// partner: rtu master feeding the receive side, draining reply and write streams
// assumes the bench calls send just after a rising edge of core_clk
`timescale 1ns/1ns
`default_nettype none

module mrw_master_model (
  input wire logic core_clk,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic rxEnd,
  output logic rxErr,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [7:0] txByte,
  output logic txReady,
  input wire logic wrValid,
  input wire logic [mrw_pkg::KIND_W-1:0] wrKind,
  input wire logic [15:0] wrAddr,
  input wire logic [15:0] wrData,
  output logic wrReady
);
  import mrw_pkg::*;
  logic [7:0] got[$];
  mrw_entry_type ent[$];
  logic slow;
  logic [1:0] cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // idle levels at time zero
  initial begin
    rxValid = 1'h0;
    rxByte = 8'h00;
    rxEnd = 1'h0;
    rxErr = 1'h0;
    txReady = 1'h0;
    wrReady = 1'h0;
    slow = 1'h0;
    cnt = 2'h0;
  end

  // capture replies and entries; slow mode stalls both consumers unevenly
  always @(posedge core_clk) begin
    cnt <= cnt + 2'h1;
    if (txValid && txReady) got.push_back(txByte);
    if (wrValid && wrReady) ent.push_back({wrKind, wrAddr, wrData});
    txReady <= !slow || cnt[0];
    wrReady <= !slow || (cnt == 2'h3);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // hold the request until an edge samples rxReady high, bounded
  task automatic take(output bit ok);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!rxReady && n < 500);
    ok = rxReady;
  endtask

  task automatic send(input logic [7:0] f[$], input int errAt, output bit ok);
    bit t;
    ok = 1;
    foreach (f[i]) begin
      rxValid <= 1'h1;
      rxByte <= f[i];
      rxErr <= (i == errAt);
      take(t);
      ok &= t;
    end
    rxValid <= 1'h0;
    rxByte <= ~f[f.size()-1]; // released line must not look like the last byte
    rxErr <= 1'h0;
    rxEnd <= 1'h1;
    take(t);
    ok &= t;
    rxEnd <= 1'h0;
  endtask
endmodule

`default_nettype wire

// File: verification/mrw_handler_tb.sv
// self-checking bench for the register write handler
// assumes the master model answers both stream handshakes
`timescale 1ns/1ns
`default_nettype none

module mrw_handler_tb;
  import mrw_pkg::*;
  logic core_clk, arst_n, rxValid, rxEnd, rxErr, rxReady, txValid, txReady;
  logic wrValid, wrReady, frameDrop;
  logic [7:0] ownAddr, rxByte, txByte;
  logic [KIND_W-1:0] wrKind;
  logic [15:0] wrAddr, wrData;
  logic [15:0] none[$], wq[$];
  logic [7:0] fq[$];
  int n_errors, n_compared, drops;

  mrw_handler dut (.core_clk(core_clk), .arst_n(arst_n), .ownAddr(ownAddr),
    .rxValid(rxValid), .rxByte(rxByte), .rxEnd(rxEnd), .rxErr(rxErr), .rxReady(rxReady),
    .txValid(txValid), .txByte(txByte), .txReady(txReady), .wrValid(wrValid),
    .wrKind(wrKind), .wrAddr(wrAddr), .wrData(wrData), .wrReady(wrReady),
    .frameDrop(frameDrop));
  mrw_master_model m (.core_clk(core_clk), .rxValid(rxValid), .rxByte(rxByte),
    .rxEnd(rxEnd), .rxErr(rxErr), .rxReady(rxReady), .txValid(txValid), .txByte(txByte),
    .txReady(txReady), .wrValid(wrValid), .wrKind(wrKind), .wrAddr(wrAddr),
    .wrData(wrData), .wrReady(wrReady));

  // 125 MHz clock
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end

  // refused frames counted here, each query checks how many it added
  always @(posedge core_clk) if (frameDrop === 1'b1) drops <= drops + 1;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    n_compared++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      n_errors++;
    end
  endtask

  // reflected crc, worked out here rather than borrowed from the design
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // send one query; mode 0 no reply, 1 echo, 2 header plus fresh crc; cm expects commit
  task automatic xfer(input logic [7:0] f[$], input int err, input int mode, input bit cm,
      input logic [15:0] a0, input logic [15:0] w[$]);
    logic [15:0] c;
    logic [7:0] r[$];
    bit ok;
    int n;
    int k;
    int d0;
    c = crc(f);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    if (err == -2) f[f.size()-1] = ~f[f.size()-1];
    if (mode == 1) r = f;
    if (mode == 2) begin
      r = f[0:5];
      c = crc(r);
      r.push_back(c[7:0]);
      r.push_back(c[15:8]);
    end
    m.got.delete();
    m.ent.delete();
    d0 = drops;
    m.send(f, err, ok);
    // broadcasts give no completion, so every query gets the processing time
    repeat (40) @(posedge core_clk);
    n = 0;
    while (!(m.got.size() >= r.size() && rxReady && !wrValid) && n < 5000) begin
      @(posedge core_clk);
      n++;
    end
    if (!ok || n == 5000) begin
      n_errors++;
      report_and_stop();
    end
    chk(m.got.size(), r.size());
    foreach (r[i]) if (i < m.got.size()) chk(m.got[i], r[i]);
    chk(drops - d0, (mode == 0 && !cm) ? 1 : 0);
    if (cm) begin
      chk(m.ent.size(), w.size() + 1);
      foreach (w[i]) if (i < m.ent.size()) chk(m.ent[i], {KIND_DATA, a0 + 16'(i), w[i]});
      if (m.ent.size() > 0) chk(m.ent[m.ent.size()-1], {KIND_COMMIT, a0, 16'h0000});
    end else begin
      k = 0;
      foreach (m.ent[i]) k += (m.ent[i].kind === KIND_COMMIT);
      chk(k, 0);
      if (m.ent.size() > 0) chk(m.ent[m.ent.size()-1].kind, KIND_ABORT);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_single();
    ownAddr <= 8'h05;
    chk(crc({8'h05, 8'h06, 8'h00, 8'h0D, 8'h17, 8'h70}), 16'h9917);
    xfer({8'h05, 8'h06, 8'h00, 8'h0D, 8'h17, 8'h70}, -1, 1, 1, 16'h000D, {16'h1770});
    xfer({8'h00, 8'h06, 8'h00, 8'h0E, 8'h12, 8'h34}, -1, 0, 1, 16'h000E, {16'h1234});
  endtask

  task automatic t_diag();
    xfer({8'h05, 8'h08, 8'h00, 8'h00, 8'hFF, 8'hFF}, -1, 1, 0, 16'h0000, none);
    xfer({8'h05, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00}, -1, 1, 0, 16'h0000, none);
    xfer({8'h00, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, -1, 0, 0, 16'h0000, none);
    xfer({8'h05, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34}, -1, 0, 0, 16'h0000, none);
  endtask

  task automatic t_multi();
    ownAddr <= 8'h19;
    m.slow <= 1'h1;
    chk(crc({8'h19, 8'h10, 8'h03, 8'hEE, 8'h00, 8'h02}), 16'h6122);
    xfer({8'h19, 8'h10, 8'h03, 8'hEE, 8'h00, 8'h02, 8'h04, 8'h00, 8'h05, 8'h00, 8'h0A},
      -1, 2, 1, 16'h03EE, {16'h0005, 16'h000A});
    m.slow <= 1'h0;
    ownAddr <= 8'h05;
  endtask

  // multiple write of n words from 0300 with a given byte count
  task automatic mk(input int n, input logic [7:0] bc);
    fq = {8'h05, 8'h10, 8'h03, 8'h00, 8'h00, 8'(n), bc};
    wq.delete();
    for (int i = 0; i < n; i++) begin
      wq.push_back(16'hA500 + 16'(i));
      fq.push_back(8'hA5);
      fq.push_back(8'(i));
    end
  endtask

  task automatic t_bounds();
    mk(125, 8'hFA);
    xfer(fq, -1, 2, 1, 16'h0300, wq);
    mk(126, 8'hFC);
    xfer(fq, -1, 0, 0, 16'h0300, wq);
    mk(1, 8'h04);
    xfer(fq, -1, 0, 0, 16'h0300, wq);
  endtask

  task automatic t_refuse();
    xfer({8'h05, 8'h06, 8'h00, 8'hC8, 8'h00, 8'h01}, -1, 0, 0, 16'h00C8, none);
    xfer({8'h05, 8'h06, 8'h01, 8'hFF, 8'h00, 8'h01}, -1, 0, 0, 16'h01FF, none);
    xfer({8'h05, 8'h06, 8'h00, 8'h0D, 8'h00, 8'h02}, -2, 0, 0, 16'h000D, none);
    xfer({8'h05, 8'h06, 8'h00, 8'h0D, 8'h00, 8'h03}, 3, 0, 0, 16'h000D, none);
    xfer({8'h07, 8'h06, 8'h00, 8'h0D, 8'h00, 8'h05}, -1, 0, 0, 16'h000D, none);
    xfer({8'h05, 8'h06, 8'h00, 8'h0D, 8'h00, 8'h04}, -1, 1, 1, 16'h000D, {16'h0004});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reset for 12 cycles, then the scenarios in turn
  initial begin
    n_errors = 0;
    n_compared = 0;
    arst_n = 1'h0;
    ownAddr = 8'h05;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
    t_single();
    t_diag();
    t_multi();
    t_bounds();
    t_refuse();
    report_and_stop();
  end
endmodule

`default_nettype wire
